// ===== common/dml_regs.vh
// Timing, geometry and memory layout constants for the dot matrix LCD driver.
`ifndef DML_REGS_VH
`define DML_REGS_VH

// Panel geometry.
`define DML_NUM_COM 17
`define DML_NUM_SEG 60
`define DML_LAST_COM_17 5'h10
`define DML_LAST_COM_16 5'h0f
`define DML_LAST_COM_8 5'h07

// Slow oscillator rate in Hz, and the last slot count: a common slot lasts that many oscillator periods plus one.
// 32768 / (17 * 64) = 30.12 Hz, 32768 / (16 * 64) = 32768 / (8 * 128) = 32 Hz.
`define DML_OSC_HZ 32768
`define DML_SLOT_OSC_NORMAL 7'h3f
`define DML_SLOT_OSC_EIGHTH 7'h7f

// Display memory: 4-bit words, offset from the base of the display region.
// Page 0 holds commons 0-7, page 1 commons 8-15, page 2 common 16 (bit 0, even words).
`define DML_MEM_AW 10
`define DML_MEM_DW 4
`define DML_PAGE_LOW 2'h0
`define DML_PAGE_HIGH 2'h1
`define DML_PAGE_C16 2'h2

`endif

// ===== rtl/dml_disp_mem.v
// Display memory: one read/write port for software and one read port for the scan.
`timescale 1ns/10ps
module dml_disp_mem #(
    parameter AW = 10,
    parameter DW = 4
) (
    input wire clk_sys,
    input wire cpu_en,
    input wire cpu_we,
    input wire [AW-1:0] cpu_addr,
    input wire [DW-1:0] cpu_wdata,
    output reg [DW-1:0] cpu_rdata,
    input wire scan_en,
    input wire [AW-1:0] scan_addr,
    output reg [DW-1:0] scan_rdata
);

    // Contents are left undefined at reset; software must initialise them.
    reg [DW-1:0] mem [0:(1<<AW)-1];

    ////////////////////////////////////////////////////////////////////////////
    // Software port, read data registered.
    always @(posedge clk_sys) begin
        if (cpu_en) begin
            if (cpu_we) begin
                mem[cpu_addr] <= cpu_wdata;
            end
            cpu_rdata <= mem[cpu_addr];
        end
    end

    // Scan port, read only, registered.
    always @(posedge clk_sys) begin
        if (scan_en) begin
            scan_rdata <= mem[scan_addr];
        end
    end

endmodule // dml_disp_mem

// ===== rtl/dml_lcd_driver.v
// Dot matrix LCD driver: common/segment scan, forcing, duty select and supply control.
`timescale 1ns/10ps
`include "dml_regs.vh"

module dml_lcd_driver #(
    parameter NUM_COM = `DML_NUM_COM,
    parameter NUM_SEG = `DML_NUM_SEG,
    parameter AW = `DML_MEM_AW,
    parameter DW = `DML_MEM_DW
) (
    input wire clk_sys,
    input wire arst_n,
    input wire slow_oscillator,
    input wire ext_supply_mode,
    input wire all_dots_on,
    input wire all_dots_off,
    input wire duty_select_high,
    input wire duty_select_low,
    input wire display_page_select,
    input wire lcd_supply_enable,
    input wire ref_voltage_select,
    input wire [3:0] contrast_level,
    input wire mem_req,
    input wire mem_we,
    input wire [AW-1:0] mem_addr,
    input wire [DW-1:0] mem_wdata,
    output wire [DW-1:0] mem_rdata,
    output reg mem_rvalid_q,
    output reg [NUM_COM-1:0] common_outputs,
    output reg [NUM_SEG-1:0] segment_outputs,
    output reg frame_polarity_q,
    output reg drive_supply_on_q,
    output reg regulator_on_q,
    output reg ref_level_second_q,
    output reg [3:0] contrast_trim_q
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding shared by the scan address and bit selection.

    // Memory word that holds the dot of common com and segment seg.
    // Layout is {page, segment, half}: page 0 holds commons 0-7, page 1
    // commons 8-15 (or the second screen at 1/8), page 2 common 16.
    function [AW-1:0] dml_dot_addr;
        input [4:0] com;
        input [5:0] seg;
        input eighth;
        input page_sel;
        reg [1:0] page;
        begin
            page = `DML_PAGE_LOW;
            if (com[4]) begin
                page = `DML_PAGE_C16;
            end else if (com[3]) begin
                page = `DML_PAGE_HIGH;
            end else if (eighth && page_sel) begin
                page = `DML_PAGE_HIGH;
            end
            // Two words per segment column; common 16 lives in the even word.
            // Address bits above the page field stay zero, so the scan never
            // strays into the spare top of the memory.
            dml_dot_addr = {{(AW-9){1'b0}}, page, seg, (com[2] & ~com[4])};
        end
    endfunction

    // Bit within the word that holds the dot of common com.
    function [1:0] dml_dot_bit;
        input [4:0] com;
        begin
            dml_dot_bit = com[4] ? 2'h0 : com[1:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Duty decode.

    // The low duty bit is ignored whenever the high bit asks for 1/8.
    // A 1/8 slot is twice as long, which keeps its frame rate equal to 1/16.
    wire duty_eighth = duty_select_high;
    wire [4:0] last_com = duty_select_high ? `DML_LAST_COM_8 :
                          (duty_select_low ? `DML_LAST_COM_16 : `DML_LAST_COM_17);
    wire [6:0] slot_last = duty_eighth ? `DML_SLOT_OSC_EIGHTH : `DML_SLOT_OSC_NORMAL;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator synchroniser and rising edge tick.

    reg osc_s1_q;
    reg osc_s2_q;
    reg osc_s3_q;
    reg ext_s1_q;
    reg ext_s2_q;

    // The first stages feed only the second stages; edges are taken after.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            osc_s1_q <= 1'b0;
            osc_s2_q <= 1'b0;
            osc_s3_q <= 1'b0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else begin
            osc_s1_q <= slow_oscillator;
            osc_s2_q <= osc_s1_q;
            osc_s3_q <= osc_s2_q;
            ext_s1_q <= ext_supply_mode;
            ext_s2_q <= ext_s1_q;
        end
    end

    // Limitation: the oscillator needs at least two system clocks per level,
    // or edges are lost and the frame rate drops.
    wire osc_tick = osc_s2_q & ~osc_s3_q;

    ////////////////////////////////////////////////////////////////////////////
    // Slot timer: each common holds for slot_last+1 oscillator periods.

    reg [6:0] slot_cnt_q;
    wire slot_end = osc_tick && (slot_cnt_q >= slot_last);

    // The compare is >= so a duty change mid-slot cannot strand the counter.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            slot_cnt_q <= 7'h00;
        end else if (slot_end) begin
            slot_cnt_q <= 7'h00;
        end else if (osc_tick) begin
            slot_cnt_q <= slot_cnt_q + 7'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Row prefetch: while one common is shown, the next row is read out.

    reg [4:0] next_com_q;
    reg [5:0] fetch_idx_q;
    reg fetch_busy_q;
    reg cap_valid_q;
    reg [5:0] cap_idx_q;
    reg [1:0] cap_bit_q;
    reg [NUM_SEG-1:0] row_buf_q;
    wire [DW-1:0] scan_rdata;
    wire [AW-1:0] scan_addr = dml_dot_addr(next_com_q, fetch_idx_q, duty_eighth,
                                           display_page_select);

    // Commons advance in ascending order and wrap at the last one in use.
    wire [4:0] after_next = (next_com_q >= last_com) ? 5'h00 : next_com_q + 5'h01;

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            next_com_q <= 5'h00;
            fetch_idx_q <= 6'h00;
            fetch_busy_q <= 1'b1;
            cap_valid_q <= 1'b0;
            cap_idx_q <= 6'h00;
            cap_bit_q <= 2'h0;
        end else begin
            cap_valid_q <= fetch_busy_q;
            cap_idx_q <= fetch_idx_q;
            cap_bit_q <= dml_dot_bit(next_com_q);
            if (slot_end) begin
                next_com_q <= after_next;
                fetch_idx_q <= 6'h00;
                fetch_busy_q <= 1'b1;
            end else if (fetch_busy_q) begin
                if (fetch_idx_q == NUM_SEG[5:0] - 6'h01) begin
                    fetch_busy_q <= 1'b0;
                end else begin
                    fetch_idx_q <= fetch_idx_q + 6'h01;
                end
            end
        end
    end

    // Captured bits: a stored one lights the dot, a zero leaves it dark.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            row_buf_q <= {NUM_SEG{1'b0}};
        end else if (cap_valid_q) begin
            row_buf_q[cap_idx_q] <= scan_rdata[cap_bit_q];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Display memory: software has its own port, so scanning never stalls it.

    dml_disp_mem #(
        .AW(AW),
        .DW(DW)
    ) u_mem (
        .clk_sys(clk_sys),
        .cpu_en(mem_req),
        .cpu_we(mem_we),
        .cpu_addr(mem_addr),
        .cpu_wdata(mem_wdata),
        .cpu_rdata(mem_rdata),
        .scan_en(fetch_busy_q),
        .scan_addr(scan_addr),
        .scan_rdata(scan_rdata)
    );

    // Read data of the software port is valid one cycle after a read request.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mem_rvalid_q <= 1'b0;
        end else begin
            mem_rvalid_q <= mem_req & ~mem_we;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shown row and common select, updated at each slot boundary.

    reg [NUM_SEG-1:0] shown_row_q;
    reg [4:0] shown_com_q;

    // The prefetched row is complete long before the boundary: 60 reads
    // against one oscillator slot of several thousand system cycles.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shown_row_q <= {NUM_SEG{1'b0}};
            shown_com_q <= 5'h00;
            frame_polarity_q <= 1'b0;
        end else if (slot_end) begin
            shown_row_q <= row_buf_q;
            shown_com_q <= next_com_q;
            if (next_com_q == 5'h00) begin
                frame_polarity_q <= ~frame_polarity_q;
            end
        end
    end

    // One-hot common drive; commons beyond the duty stay inactive.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_COM; gi = gi + 1) begin : g_com
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    common_outputs[gi] <= 1'b0;
                end else begin
                    common_outputs[gi] <= (shown_com_q == gi) && (gi <= last_com);
                end
            end
        end
    endgenerate

    // Forcing acts on the segment drive only and takes effect at once;
    // the stored row and the memory are untouched, so normal display resumes.
    // All-on is tested first, which is what gives it priority over all-off.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            segment_outputs <= {NUM_SEG{1'b0}};
        end else if (all_dots_on) begin
            segment_outputs <= {NUM_SEG{1'b1}};
        end else if (all_dots_off) begin
            segment_outputs <= {NUM_SEG{1'b0}};
        end else begin
            segment_outputs <= shown_row_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Drive supply control for the analog voltage circuit.

    // In external supply mode the regulator is off and the trim code is held
    // at zero, so the contrast setting cannot move the drive levels.
    // The drive levels themselves are analog; only their control bits live here.
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            drive_supply_on_q <= 1'b0;
            regulator_on_q <= 1'b0;
            ref_level_second_q <= 1'b0;
            contrast_trim_q <= 4'h0;
        end else begin
            drive_supply_on_q <= lcd_supply_enable;
            regulator_on_q <= lcd_supply_enable & ~ext_s2_q;
            ref_level_second_q <= ref_voltage_select;
            contrast_trim_q <= ext_s2_q ? 4'h0 : contrast_level;
        end
    end

endmodule // dml_lcd_driver

// ===== tb/dml_lcd_driver_sva.sv
// Port-level assertions for the dot matrix LCD driver.
`timescale 1ns/10ps
module dml_lcd_driver_sva #(
    parameter NUM_COM = 17,
    parameter NUM_SEG = 60
) (
    input wire clk_sys,
    input wire arst_n,
    input wire ext_supply_mode,
    input wire all_dots_on,
    input wire all_dots_off,
    input wire lcd_supply_enable,
    input wire ref_voltage_select,
    input wire [3:0] contrast_level,
    input wire mem_req,
    input wire mem_we,
    input wire mem_rvalid_q,
    input wire [NUM_COM-1:0] common_outputs,
    input wire [NUM_SEG-1:0] segment_outputs,
    input wire drive_supply_on_q,
    input wire ref_level_second_q,
    input wire [3:0] contrast_trim_q
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////
    // Scan order: one common at a time, stepping up or wrapping to common 0.
    a_com_onehot: assert property ($onehot0(common_outputs))
        else $error("two commons driven at once");
    a_com_ascend: assert property (
        $changed(common_outputs) && common_outputs != 0 && $past(common_outputs) != 0
        |-> common_outputs == $past(common_outputs) << 1 || common_outputs == 1)
        else $error("common order broken");
    // Forcing; three cycles of hold keep the first edge after reset out of it.
    a_force_on: assert property (all_dots_on [*3] |-> &segment_outputs)
        else $error("segments not all on");
    a_force_off: assert property (
        (all_dots_off && !all_dots_on) [*3] |-> segment_outputs == 0)
        else $error("segments not all off");
    // Memory port: a read answers one cycle later, a write never does.
    a_read_answer: assert property (mem_req |=> mem_rvalid_q == !$past(mem_we))
        else $error("read valid wrong after request");
    a_no_answer: assert property (!mem_req |=> !mem_rvalid_q)
        else $error("read valid without request");
    // The strap passes a 2FF synchroniser, hence the four-cycle hold.
    a_contrast_copy: assert property (
        !ext_supply_mode [*4] |=> contrast_trim_q == $past(contrast_level))
        else $error("contrast code not applied");
    a_ext_contrast: assert property (ext_supply_mode [*4] |=> contrast_trim_q == 4'h0)
        else $error("contrast active with outside supply");
    a_supply_on: assert property (lcd_supply_enable [*2] |-> drive_supply_on_q)
        else $error("supply not switched on");
    a_ref_copy: assert property (
        $past(arst_n) |-> ref_level_second_q == $past(ref_voltage_select))
        else $error("reference select not followed");
    ////////////////////////////////////////
    c_both_forced: cover property (all_dots_on && all_dots_off);
    c_last_common: cover property (common_outputs[NUM_COM-1]);
    c_read: cover property (mem_req && !mem_we);
endmodule // dml_lcd_driver_sva

// ===== tb/dml_panel_model.sv
// Behavioural passive panel that remembers the row shown on each common.
`timescale 1ns/10ps
module dml_panel_model (
    input wire clk_sys,
    input wire clr,
    input wire [16:0] common_outputs,
    input wire [59:0] segment_outputs,
    output reg [4:0] top_com_q
);
    reg [59:0] rows_q [0:16];
    integer i;
    // The glass only ever listens, so the model just latches rows and the highest common seen.
    always @(posedge clk_sys) begin
        if (clr)
            top_com_q <= 5'h0;
        for (i = 0; i < 17; i = i + 1) begin
            if (common_outputs[i]) begin
                rows_q[i] <= segment_outputs;
                if (i > top_com_q)
                    top_com_q <= i[4:0];
            end
        end
    end
endmodule // dml_panel_model

// ===== tb/dml_lcd_driver_tb.sv
// Self-checking bench for the dot matrix LCD driver.
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    $display("wrong value %s expected %0h seen %0h", n, e, g); num_errors++; end end
module dml_lcd_driver_tb;
    reg clk_sys = 1'b0, arst_n = 1'b0, slow_oscillator = 1'b0, ext_supply_mode = 1'b0;
    reg all_dots_on = 1'b0, all_dots_off = 1'b0, duty_select_high = 1'b0, duty_select_low = 1'b0;
    reg display_page_select = 1'b0, lcd_supply_enable = 1'b0, ref_voltage_select = 1'b0;
    reg [3:0] contrast_level = 4'h7;
    reg mem_req = 1'b0, mem_we = 1'b0, clr = 1'b0, pol;
    reg [9:0] mem_addr = 10'h000;
    reg [3:0] mem_wdata = 4'h0, d;
    reg [13:0] mt [0:3];
    reg [2:0] ft [0:4];
    wire [3:0] mem_rdata, contrast_trim_q;
    wire [16:0] common_outputs;
    wire [59:0] segment_outputs;
    wire [4:0] top_com;
    wire mem_rvalid_q, drive_supply_on_q, ref_level_second_q, frame_polarity_q, regulator_on_q;
    integer num_errors = 0, total_checks = 0, cyc = 0, i, s, w, b, c, n, t0, t1, len;
    // An oscillator period of eight system clocks keeps each frame near 8k cycles.
    always #5 clk_sys = ~clk_sys;
    always #40 slow_oscillator = ~slow_oscillator;
    always @(posedge clk_sys) cyc <= cyc + 1;
    dml_lcd_driver u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .slow_oscillator(slow_oscillator),
        .ext_supply_mode(ext_supply_mode), .all_dots_on(all_dots_on), .all_dots_off(all_dots_off),
        .duty_select_high(duty_select_high), .duty_select_low(duty_select_low),
        .display_page_select(display_page_select), .lcd_supply_enable(lcd_supply_enable),
        .ref_voltage_select(ref_voltage_select), .contrast_level(contrast_level),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_rvalid_q(mem_rvalid_q), .common_outputs(common_outputs),
        .segment_outputs(segment_outputs), .frame_polarity_q(frame_polarity_q),
        .drive_supply_on_q(drive_supply_on_q), .regulator_on_q(regulator_on_q),
        .ref_level_second_q(ref_level_second_q), .contrast_trim_q(contrast_trim_q));
    dml_panel_model u_panel (.clk_sys(clk_sys), .clr(clr), .common_outputs(common_outputs),
        .segment_outputs(segment_outputs), .top_com_q(top_com));
    ////////////////////////////////////////
    // Dot pattern of common c, segment s; it differs between the two 1/8 screens.
    function dot(input integer c, input integer s);
        dot = ((c + 2 * s) % 3) != 0;
    endfunction
    function [59:0] xrow(input integer c);
        integer s;
        begin
            for (s = 0; s < 60; s = s + 1)
                xrow[s] = dot(c, s);
        end
    endfunction
    // One memory access for one rising edge; returns where a read answer stands.
    task acc(input w, input [9:0] a, input [3:0] d);
        begin
            @(negedge clk_sys);
            mem_req = 1'b1;
            mem_we = w;
            mem_addr = a;
            mem_wdata = d;
            @(negedge clk_sys);
            mem_req = 1'b0;
        end
    endtask
    task rd_chk(input [9:0] a, input [3:0] e);
        begin
            acc(1'b0, a, 4'h0);
            `CHK("read valid", 1'b1, mem_rvalid_q)
            `CHK("read data", e, mem_rdata)
        end
    endtask
    // Waits for common 0 to start a frame; a hang is cut off after 40000 cycles.
    task com0_rise(output integer t);
        integer k;
        begin
            for (k = 0; k < 40000 && common_outputs[0] === 1'b1; k = k + 1)
                @(negedge clk_sys);
            for (k = k; k < 40000 && common_outputs[0] !== 1'b1; k = k + 1)
                @(negedge clk_sys);
            t = cyc;
            `CHK("frame start wait", 1'b1, k < 40000)
            if (k >= 40000)
                report_and_stop;
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", total_checks, num_errors);
            if (num_errors == 0 && total_checks > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    ////////////////////////////////////////
    initial begin
        mt[0] = {10'h000, 4'ha};
        mt[1] = {10'h0f7, 4'h5};
        mt[2] = {10'h100, 4'h1};
        mt[3] = {10'h076, 4'hc};
        ft[0] = 3'b000;
        ft[1] = 3'b011;
        ft[2] = 3'b100;
        ft[3] = 3'b101;
        ft[4] = 3'b110;
        repeat (12) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("commons in reset", 17'h0, common_outputs)
        `CHK("segments in reset", 60'h0, segment_outputs)
        arst_n = 1'b1;
        for (i = 0; i < 4; i = i + 1)
            acc(1'b1, mt[i][13:4], mt[i][3:0]);
        for (i = 0; i < 4; i = i + 1)
            rd_chk(mt[i][13:4], mt[i][3:0]);
        // Word w: pages 0 and 1 in two halves, then page 2 with common 16 in bit 0 only.
        for (s = 0; s < 60; s = s + 1)
            for (w = 0; w < 5; w = w + 1) begin
                for (b = 0; b < 4; b = b + 1)
                    d[b] = dot(w * 4 + b, s) && (w < 4 || b == 0);
                acc(1'b1, {1'b0, w[2:1], s[5:0], w[0]}, d);
            end
        // Each duty row: one full frame is judged on glass, polarity, reach and length.
        for (i = 0; i < 5; i = i + 1) begin
            {duty_select_high, duty_select_low, display_page_select} = ft[i];
            n = ft[i][2] ? 8 : (ft[i][1] ? 16 : 17);
            len = n * 8 * (ft[i][2] ? 128 : 64);
            com0_rise(t0);
            pol = frame_polarity_q;
            clr = 1'b1;
            @(negedge clk_sys);
            clr = 1'b0;
            com0_rise(t1);
            `CHK("frame polarity", ~pol, frame_polarity_q)
            repeat (3) @(negedge clk_sys);
            `CHK("frame length", 1'b1, (t1 - t0 - len) * (t1 - t0 - len) <= 4)
            `CHK("top common", n[4:0] - 5'h1, top_com)
            for (c = 0; c < n; c = c + 1)
                `CHK("row", xrow(c + (ft[i][2] & ft[i][0]) * 8), u_panel.rows_q[c])
        end
        // Codes 1, 2, 3: on alone, off alone, then both with on winning.
        for (i = 1; i < 5; i = i + 1) begin
            @(negedge clk_sys);
            {all_dots_off, all_dots_on} = i[1:0];
            repeat (2) @(negedge clk_sys);
            if (i < 4)
                `CHK("forced segments", {60{i[0]}}, segment_outputs)
        end
        rd_chk(10'h000, 4'h6);
        // Supply is raised only after the glass checks, so none leans on a settling level.
        for (i = 0; i < 16; i = i + 1) begin
            contrast_level = i[3:0];
            {lcd_supply_enable, ref_voltage_select} = i[1:0];
            repeat (2) @(negedge clk_sys);
            `CHK("contrast", i[3:0], contrast_trim_q)
            `CHK("supply", i[1], drive_supply_on_q)
            `CHK("regulator", i[1], regulator_on_q)
            `CHK("reference", i[0], ref_level_second_q)
        end
        ext_supply_mode = 1'b1;
        repeat (6) @(negedge clk_sys);
        `CHK("outside supply contrast", 4'h0, contrast_trim_q)
        `CHK("outside supply regulator", 1'b0, regulator_on_q)
        // Reset in mid-run while the inputs still ask for supply and reference.
        arst_n = 1'b0;
        @(negedge clk_sys);
        `CHK("reference in reset", 1'b0, ref_level_second_q)
        `CHK("supply in reset", 1'b0, drive_supply_on_q)
        `CHK("commons in mid reset", 17'h0, common_outputs)
        arst_n = 1'b1;
        repeat (2) @(negedge clk_sys);
        `CHK("reference after reset", 1'b1, ref_level_second_q)
        report_and_stop;
    end
endmodule // dml_lcd_driver_tb
bind dml_lcd_driver dml_lcd_driver_sva #(.NUM_COM(NUM_COM), .NUM_SEG(NUM_SEG)) u_sva (
    .clk_sys(clk_sys), .arst_n(arst_n), .ext_supply_mode(ext_supply_mode),
    .all_dots_on(all_dots_on), .all_dots_off(all_dots_off), .lcd_supply_enable(lcd_supply_enable),
    .ref_voltage_select(ref_voltage_select), .contrast_level(contrast_level), .mem_req(mem_req),
    .mem_we(mem_we), .mem_rvalid_q(mem_rvalid_q), .common_outputs(common_outputs),
    .segment_outputs(segment_outputs), .drive_supply_on_q(drive_supply_on_q),
    .ref_level_second_q(ref_level_second_q), .contrast_trim_q(contrast_trim_q));
